// file: dv/cppc_asserts.sv
// concurrent checks on the power-path control ports
`timescale 1ns/1ps
module cppc_asserts
  import cppc_pkg::*;
#(
  parameter int unsigned TURBO_EXIT_CYCLES = TURBO_EXIT_CYC
) (
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic [7:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_bat_above_min,
  input wire logic        i_adp_above_min,
  input wire logic        i_battery_absent_input,
  input wire logic        i_adp_cur_at_limit,
  input wire logic        i_adp_volt_at_ref,
  input wire logic        o_strap_current_en,
  input wire logic        o_adapter_switch_gate,
  input wire logic        o_battery_switch_gate,
  input wire logic        o_switcher_en,
  input wire logic        o_charge_en,
  input wire logic        o_input_limit_active,
  input wire logic [1:0]  o_input_vref_sel,
  input wire logic [2:0]  o_freq_sel
);
  logic [15:0] cfg_q;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // last accepted write data, so field checks need no deep past
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_q <= 16'h0000;
    end else if (i_avs_write && !o_avs_waitrequest) begin
      cfg_q <= i_avs_writedata[15:0];
    end
  end
  sequence s_take(logic [7:0] ofs);
    i_avs_write && !o_avs_waitrequest && i_avs_address == ofs && i_avs_byteenable[1:0] == 2'h3;
  endsequence
  a_wait_drop: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("waitrequest held past one wait state");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_strap_first: assert property ($rose(o_strap_current_en) |-> !o_adapter_switch_gate)
    else $error("strap current started with adapter gate closed");
  a_switch_adp: assert property ($rose(o_switcher_en) |-> o_adapter_switch_gate)
    else $error("switcher started without adapter gate");
  a_charge_absent: assert property (i_battery_absent_input [*4] |=> !o_charge_en)
    else $error("charging with battery absent");
  a_charge_gate: assert property (o_charge_en |-> ##[0:2] o_battery_switch_gate)
    else $error("charging with battery gate open");
  a_limit_on: assert property ((o_adapter_switch_gate && (i_adp_cur_at_limit || i_adp_volt_at_ref)) [*4]
    |=> o_input_limit_active) else $error("input limit not applied");
  a_freq_follow: assert property (s_take(OFS_CFG1) ##0 !i_avs_writedata[CFG1_PWRMON]
    |-> ##[1:2] o_freq_sel == cfg_q[9:7]) else $error("frequency field not applied");
  a_vref_follow: assert property (s_take(OFS_CFG0) |-> ##[1:2] o_input_vref_sel == cfg_q[1:0])
    else $error("voltage reference select not applied");
  a_bat_only: assert property ((i_bat_above_min && !i_adp_above_min) [*8] |=> o_battery_switch_gate)
    else $error("battery gate open in battery-only mode");
endmodule // cppc_asserts

bind cppc_top cppc_asserts #(.TURBO_EXIT_CYCLES(TURBO_EXIT_CYCLES)) i_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable), .o_avs_waitrequest(o_avs_waitrequest),
  .i_bat_above_min(i_bat_above_min), .i_adp_above_min(i_adp_above_min),
  .i_battery_absent_input(i_battery_absent_input), .i_adp_cur_at_limit(i_adp_cur_at_limit),
  .i_adp_volt_at_ref(i_adp_volt_at_ref), .o_strap_current_en(o_strap_current_en),
  .o_adapter_switch_gate(o_adapter_switch_gate), .o_battery_switch_gate(o_battery_switch_gate),
  .o_switcher_en(o_switcher_en), .o_charge_en(o_charge_en), .o_input_limit_active(o_input_limit_active),
  .o_input_vref_sel(o_input_vref_sel), .o_freq_sel(o_freq_sel));

// file: dv/cppc_host.sv
// host model: programs the block over the register bus
`timescale 1ns/1ps
module cppc_host (
  input  wire logic        i_clk,
  input  wire logic        i_waitrequest,
  input  wire logic [31:0] i_readdata,
  output logic [7:0]       o_address = 8'h00,
  output logic             o_read = 1'b0,
  output logic             o_write = 1'b0,
  output logic [31:0]      o_writedata = 32'h0000_0000,
  output logic [3:0]       o_byteenable = 4'h0
);
  // one access; learn commands go out as ordinary writes, no side channel
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] q);
    o_address <= a;
    o_writedata <= {16'h0000, d};
    o_byteenable <= 4'h3;
    o_write <= w;
    o_read <= ~w;
    do begin
      @(posedge i_clk);
    end while (i_waitrequest !== 1'b0);
    q = i_readdata;
    o_write <= 1'b0;
    o_read <= 1'b0;
    // released address and data lines show junk so stale values are never trusted
    o_address <= ~a;
    o_writedata <= ~{16'h0000, d};
    // one idle edge so the next call never reassigns a line in this time step
    @(posedge i_clk);
  endtask
endmodule // cppc_host

// file: dv/tb_charger_power_path_control.sv
// self-checking bench for the charger power-path control block
`timescale 1ns/1ps
module tb_charger_power_path_control;
  import cppc_pkg::*;
  localparam int unsigned TEXIT = 50;
  logic        i_core_clk;
  logic        i_rst = 1'b1;
  logic [7:0]  i_avs_address;
  logic        i_avs_read, i_avs_write;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [3:0]  i_avs_byteenable;
  logic        o_avs_waitrequest, o_strap_current_en, o_adapter_switch_gate, o_battery_switch_gate;
  logic        o_switcher_en, o_charge_en, o_input_limit_active, o_period_stretch;
  logic        o_system_power_monitor, o_battery_current_monitor;
  logic [15:0] o_input_limit_sel;
  logic [1:0]  o_input_vref_sel;
  logic [2:0]  o_freq_sel;
  logic        bmin = 1'b0, amin = 1'b0, bpm = 1'b0, bias = 1'b0, absent = 1'b0, rbat = 1'b0, rmarg = 1'b0;
  logic        brmin = 1'b0, bvmax = 1'b0, acur = 1'b0, avolt = 1'b0, ccur = 1'b0, dlow = 1'b0, tload = 1'b0;
  logic        lshort = 1'b0;
  logic [3:0]  strap = 4'h8;
  int          bad_count = 0;
  int          checks_done = 0;

  cppc_host i_host (.i_clk(i_core_clk), .i_waitrequest(o_avs_waitrequest), .i_readdata(o_avs_readdata),
    .o_address(i_avs_address), .o_read(i_avs_read), .o_write(i_avs_write), .o_writedata(i_avs_writedata),
    .o_byteenable(i_avs_byteenable));
  cppc_top #(.TURBO_EXIT_CYCLES(TEXIT)) i_dut (.i_core_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_bat_above_min(bmin),
    .i_adp_above_min(amin), .i_bat_above_pwrmon(bpm), .i_bias_ok(bias), .i_battery_absent_input(absent),
    .i_rail_at_battery(rbat), .i_rail_below_bat_margin(rmarg), .i_bat_below_rail_min(brmin),
    .i_bat_below_vmax(bvmax), .i_adp_cur_at_limit(acur), .i_adp_volt_at_ref(avolt), .i_chg_cur_detect(ccur),
    .i_dischg_low(dlow), .i_turbo_load(tload), .i_lowside_short(lshort), .i_strap_code(strap),
    .o_strap_current_en, .o_adapter_switch_gate, .o_battery_switch_gate, .o_switcher_en, .o_charge_en,
    .o_input_limit_active, .o_input_limit_sel, .o_input_vref_sel, .o_freq_sel, .o_system_power_monitor,
    .o_battery_current_monitor, .o_period_stretch);

  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    i_host.acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_host.acc(1'b0, a, 16'h0000, q);
    chk(q, exp);
  endtask
  // bounded wait: sel 0 strap current, 1 adapter gate
  task automatic wait_on(input int sel, input int lim);
    int n;
    n = 0;
    while ((sel == 0 ? o_strap_current_en : o_adapter_switch_gate) !== 1'b1 && n < lim) begin
      @(posedge i_core_clk);
      n++;
    end
    chkb(n < lim, 1'b1);
  endtask

  task automatic t_battery();
    rdc(OFS_LIM2, {16'h0000, LIM2_RST});
    rdc(8'h30, UNMAPPED_RD);
    bmin <= 1'b1;
    cyc(10);
    chkb(o_battery_switch_gate, 1'b1);
    chkb(o_strap_current_en, 1'b0);
    wr(OFS_CFG1, 16'h0010);
    cyc(6);
    chkb(o_battery_current_monitor, 1'b1);
    chkb(o_system_power_monitor, 1'b0);
    wr(OFS_VMAX, 16'h1234);
    bpm <= 1'b1;
    wr(OFS_CFG1, 16'h0018);
    wait_on(0, 100);
    cyc(900);
    chkb(o_system_power_monitor, 1'b1);
    chkb(o_battery_current_monitor, 1'b0);
    rdc(OFS_VMAX, {16'h0000, VMAX_2S});
    rdc(OFS_VMIN, {16'h0000, VMIN_2S});
  endtask
  task automatic t_adapter();
    wr(OFS_VMAX, 16'h1111);
    wr(OFS_LIM1, 16'h0100);
    bias <= 1'b1;
    amin <= 1'b1;
    wait_on(1, 3000);
    cyc(6);
    chkb(o_switcher_en, 1'b1);
    rdc(OFS_LIM1, {16'h0000, LIM1_A15});
    rdc(OFS_VMAX, 32'h0000_1111);
    amin <= 1'b0;
    cyc(10);
    wr(OFS_CFG1, 16'h0000);
    amin <= 1'b1;
    wait_on(1, 3000);
    cyc(6);
    rdc(OFS_VMAX, {16'h0000, VMAX_2S});
  endtask
  task automatic t_limits();
    wr(OFS_CFG1, 16'h0280);
    wr(OFS_CFG0, 16'h0002);
    avolt <= 1'b1;
    cyc(6);
    chk(o_freq_sel, 32'h0000_0005);
    chk(o_input_vref_sel, 32'h0000_0002);
    chkb(o_input_limit_active, 1'b1);
    avolt <= 1'b0;
    acur <= 1'b1;
    cyc(6);
    chkb(o_input_limit_active, 1'b1);
    acur <= 1'b0;
    chk(o_input_limit_sel, {16'h0000, LIM1_A15});
    lshort <= 1'b1;
    wr(OFS_CFG2, 16'h1000);
    cyc(3);
    chk(o_input_limit_sel, {16'h0000, LIM2_RST});
    chkb(o_period_stretch, 1'b1);
    lshort <= 1'b0;
    wr(OFS_CFG2, 16'h0000);
    cyc(4);
    chkb(o_period_stretch, 1'b0);
  endtask
  task automatic t_charge();
    wr(OFS_CHG, 16'h0200);
    cyc(6);
    chkb(o_charge_en, 1'b1);
    chkb(o_battery_switch_gate, 1'b1);
    absent <= 1'b1;
    cyc(6);
    chkb(o_charge_en, 1'b0);
    absent <= 1'b0;
    wr(OFS_CHG, 16'h0000);
    cyc(6);
    chkb(o_battery_switch_gate, 1'b0);
  endtask
  // margin is a pulse: the gate itself lifts the rail back, so exit must not need it low
  task automatic t_turbo();
    tload <= 1'b1;
    rmarg <= 1'b1;
    cyc(6);
    chkb(o_battery_switch_gate, 1'b1);
    rmarg <= 1'b0;
    ccur <= 1'b1;
    cyc(6);
    chkb(o_battery_switch_gate, 1'b0);
    ccur <= 1'b0;
    rmarg <= 1'b1;
    cyc(6);
    rmarg <= 1'b0;
    dlow <= 1'b1;
    cyc(TEXIT / 2);
    chkb(o_battery_switch_gate, 1'b1);
    cyc(TEXIT);
    chkb(o_battery_switch_gate, 1'b0);
    dlow <= 1'b0;
    wr(OFS_CFG0, 16'h0001);
    rmarg <= 1'b1;
    cyc(6);
    chkb(o_battery_switch_gate, 1'b0);
    rmarg <= 1'b0;
    tload <= 1'b0;
  endtask
  task automatic t_learn();
    wr(OFS_CMD, 16'h0001);
    cyc(6);
    chkb(o_battery_switch_gate, 1'b0);
    rbat <= 1'b1;
    cyc(6);
    chkb(o_battery_switch_gate, 1'b1);
    chkb(o_adapter_switch_gate, 1'b1);
    chkb(o_switcher_en, 1'b0);
    wr(OFS_CMD, 16'h0002);
    cyc(2);
    chkb(o_switcher_en, 1'b1);
    for (int k = 0; k < 3; k++) begin
      wr(OFS_CFG1, (k == 1) ? 16'h1000 : 16'h0000);
      wr(OFS_CMD, 16'h0001);
      cyc(6);
      chkb(o_switcher_en, 1'b0);
      brmin <= (k == 0);
      bvmax <= (k == 1);
      absent <= (k == 2);
      lshort <= ~lshort;
      cyc(6);
      chkb(o_switcher_en, 1'b1);
      brmin <= 1'b0;
      bvmax <= 1'b0;
      absent <= 1'b0;
      cyc(6);
    end
  endtask

  initial begin
    cyc(6);
    i_rst <= 1'b0;
    cyc(1);
    t_battery();
    t_adapter();
    t_limits();
    t_charge();
    t_turbo();
    t_learn();
    wrap_up();
  end
  initial begin
    cyc(60000);
    bad_count++;
    wrap_up();
  end
endmodule // tb_charger_power_path_control

// file: src/cppc_pkg.sv
// shared constants for the charger power-path control block
package cppc_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TURBO_EXIT_MS = 20;
  localparam int unsigned TURBO_EXIT_CYC = CLK_HZ / 1000 * TURBO_EXIT_MS;
  localparam int unsigned STRAP_SETTLE_US = 40;
  localparam int unsigned STRAP_SETTLE_CYC = (CLK_HZ / 1_000_000) * STRAP_SETTLE_US;
  // register byte offsets
  localparam logic [7:0] OFS_CFG0 = 8'h00;
  localparam logic [7:0] OFS_CFG1 = 8'h04;
  localparam logic [7:0] OFS_CFG2 = 8'h08;
  localparam logic [7:0] OFS_LIM1 = 8'h0C;
  localparam logic [7:0] OFS_LIM2 = 8'h10;
  localparam logic [7:0] OFS_VMAX = 8'h14;
  localparam logic [7:0] OFS_VMIN = 8'h18;
  localparam logic [7:0] OFS_CHG  = 8'h1C;
  localparam logic [7:0] OFS_CMD  = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  // field positions
  localparam int unsigned CFG0_TURBO_DIS = 0;
  localparam int unsigned CFG0_VREF_LO   = 0;
  localparam int unsigned CFG1_PWRMON    = 3;
  localparam int unsigned CFG1_BATMON    = 4;
  localparam int unsigned CFG1_FREQ_LO   = 7;
  localparam int unsigned CFG1_LEARN_EXIT = 12;
  localparam int unsigned CFG2_TWO_LEVEL = 12;
  localparam int unsigned CMD_LEARN_ENTER = 0;
  localparam int unsigned CMD_LEARN_EXIT  = 1;
  // reset and default values (1 mA per lsb for limits, 1 mV per lsb for VMAX and VMIN)
  localparam logic [15:0] LIM2_RST = 16'h05DC;
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam logic [15:0] LIM1_A01  = 16'h0064;
  localparam logic [15:0] LIM1_A048 = 16'h01DC;
  localparam logic [15:0] LIM1_A15  = 16'h05DC;
  localparam logic [15:0] VMAX_1S = 16'h1068;
  localparam logic [15:0] VMAX_2S = 16'h20D0;
  localparam logic [15:0] VMAX_3S = 16'h3138;
  localparam logic [15:0] VMIN_1S = 16'h0C00;
  localparam logic [15:0] VMIN_2S = 16'h1800;
  localparam logic [15:0] VMIN_3S = 16'h2400;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  typedef enum logic [1:0] {CPPC_OFF, CPPC_BAT, CPPC_ADP, CPPC_LEARN} cppc_mode_t;
endpackage

// file: src/cppc_top.sv
// power-path selection, strap decode, learn and peak-assist control
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module cppc_top
  import cppc_pkg::*;
#(
  parameter int unsigned TURBO_EXIT_CYCLES = TURBO_EXIT_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_bat_above_min,
  input  wire logic        i_adp_above_min,
  input  wire logic        i_bat_above_pwrmon,
  input  wire logic        i_bias_ok,
  input  wire logic        i_battery_absent_input,
  input  wire logic        i_rail_at_battery,
  input  wire logic        i_rail_below_bat_margin,
  input  wire logic        i_bat_below_rail_min,
  input  wire logic        i_bat_below_vmax,
  input  wire logic        i_adp_cur_at_limit,
  input  wire logic        i_adp_volt_at_ref,
  input  wire logic        i_chg_cur_detect,
  input  wire logic        i_dischg_low,
  input  wire logic        i_turbo_load,
  input  wire logic        i_lowside_short,
  input  wire logic [3:0]  i_strap_code,
  output logic             o_strap_current_en,
  output logic             o_adapter_switch_gate,
  output logic             o_battery_switch_gate,
  output logic             o_switcher_en,
  output logic             o_charge_en,
  output logic             o_input_limit_active,
  output logic [15:0]      o_input_limit_sel,
  output logic [1:0]       o_input_vref_sel,
  output logic [2:0]       o_freq_sel,
  output logic             o_system_power_monitor,
  output logic             o_battery_current_monitor,
  output logic             o_period_stretch
);
  import cppc_pkg::*;

  // two-flop synchronisers; the strap code is static while its test current settles
  localparam int unsigned NS = 19;
  logic [NS-1:0] s1, s2, raw;
  assign raw = {i_bat_above_min, i_adp_above_min, i_bat_above_pwrmon, i_bias_ok, i_battery_absent_input,
                i_rail_at_battery, i_rail_below_bat_margin, i_bat_below_rail_min, i_bat_below_vmax,
                i_adp_cur_at_limit, i_adp_volt_at_ref, i_chg_cur_detect, i_dischg_low, i_turbo_load,
                i_lowside_short, i_strap_code};
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s1 <= '0;
      s2 <= '0;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end
  logic bat_ok, adp_ok, bat_pm_ok, bias_ok, bat_gone, rail_dec, rail_margin, bat_lt_min, bat_lt_max;
  logic adp_ilim, adp_vlim, chg_det, dis_low, turbo_ld, ls_short;
  assign {bat_ok, adp_ok, bat_pm_ok, bias_ok, bat_gone, rail_dec, rail_margin, bat_lt_min, bat_lt_max,
          adp_ilim, adp_vlim, chg_det, dis_low, turbo_ld, ls_short} = s2[NS-1:4];
  logic [3:0] strap_in;
  assign strap_in = s2[3:0];

  // registers
  logic [15:0] cfg0, cfg1, cfg2, lim1, lim2, vmax, vmin, chg;
  logic        strap_valid;
  logic [3:0]  strap;
  logic        bat_gone_q, adp_q, pm_q;
  cppc_mode_t  mode;
  logic        learn_pend;
  logic        turbo;
  logic [$clog2(TURBO_EXIT_CYCLES+1)-1:0] dis_cnt;

  function automatic logic [15:0] lim1_default(input logic [3:0] code);
    logic [3:0] pos;
    pos = (code < 4'h6) ? code : (code - 4'h1) % 4'h5;
    unique case (pos)
      4'h0, 4'h5: lim1_default = LIM1_A01;
      4'h1, 4'h3: lim1_default = LIM1_A048;
      default:    lim1_default = LIM1_A15;
    endcase
  endfunction
  function automatic logic [1:0] cells(input logic [3:0] code);
    cells = (code > 4'hA) ? 2'h3 : ((code > 4'h5) ? 2'h2 : 2'h1);
  endfunction
  function automatic logic [15:0] vmax_default(input logic [3:0] code);
    unique case (cells(code))
      2'h1:    vmax_default = VMAX_1S;
      2'h2:    vmax_default = VMAX_2S;
      default: vmax_default = VMAX_3S;
    endcase
  endfunction
  function automatic logic [15:0] vmin_default(input logic [3:0] code);
    unique case (cells(code))
      2'h1:    vmin_default = VMIN_1S;
      2'h2:    vmin_default = VMIN_2S;
      default: vmin_default = VMIN_3S;
    endcase
  endfunction
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // strap read sequencer: test current on, settle, then sample
  logic [$clog2(STRAP_SETTLE_CYC+1)-1:0] settle;
  logic strap_req, strap_done;
  logic adp_rise, pm_rise;
  assign adp_rise = adp_ok & ~adp_q;
  assign pm_rise  = cfg1[CFG1_PWRMON] & ~pm_q;
  // battery start skips the strap until monitor on; adapter needs it before its gate closes
  assign strap_req = (adp_rise & ~strap_valid) | (mode == CPPC_BAT && pm_rise && bat_pm_ok);
  assign strap_done = o_strap_current_en && (settle == STRAP_SETTLE_CYC[$bits(settle)-1:0]);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_strap_current_en <= 1'b0;
      settle <= '0;
    end else if (strap_done) begin
      o_strap_current_en <= 1'b0;
      settle <= '0;
    end else if (strap_req | o_strap_current_en) begin
      o_strap_current_en <= 1'b1;
      settle <= settle + 1'b1;
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      strap <= '0;
      strap_valid <= 1'b0;
    end else if (strap_done) begin
      strap <= strap_in;
      strap_valid <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bat_gone_q <= 1'b0;
      adp_q <= 1'b0;
      pm_q <= 1'b0;
    end else begin
      bat_gone_q <= bat_gone;
      adp_q <= adp_ok;
      pm_q <= cfg1[CFG1_PWRMON];
    end
  end

  // bus slave: one wait cycle, request taken when waitrequest low
  logic wr_go, rd_load;
  assign wr_go = i_avs_write & ~o_avs_waitrequest;
  // read data load in the wait cycle so they stand at the accepting edge
  assign rd_load = i_avs_read & o_avs_waitrequest;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
    end
  end
  logic adp_reload, cfg_reload;
  assign adp_reload = strap_valid && adp_q && !adp_ok ? 1'b0 : (adp_rise | (strap_done & adp_ok));
  assign cfg_reload = strap_done & (mode == CPPC_BAT);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg0 <= CFG_RST;
      cfg1 <= CFG_RST;
      cfg2 <= CFG_RST;
      lim1 <= LIM1_A01;
      lim2 <= LIM2_RST;
      vmax <= VMAX_1S;
      vmin <= VMIN_1S;
      chg  <= '0;
    end else begin
      if (cfg_reload) begin
        cfg0 <= CFG_RST;
        cfg1 <= cfg1 & (16'h1 << CFG1_PWRMON);
        cfg2 <= CFG_RST;
        lim2 <= LIM2_RST;
        chg  <= '0;
      end else if (wr_go) begin
        unique case (i_avs_address)
          OFS_CFG0: cfg0 <= merge(cfg0, i_avs_writedata, i_avs_byteenable);
          OFS_CFG1: cfg1 <= merge(cfg1, i_avs_writedata, i_avs_byteenable);
          OFS_CFG2: cfg2 <= merge(cfg2, i_avs_writedata, i_avs_byteenable);
          OFS_LIM2: lim2 <= merge(lim2, i_avs_writedata, i_avs_byteenable);
          OFS_CHG:  chg  <= merge(chg, i_avs_writedata, i_avs_byteenable);
          default: ;
        endcase
      end
      // power monitor not allowed in battery mode below its threshold
      if (mode == CPPC_BAT && !bat_pm_ok && cfg1[CFG1_PWRMON]) begin
        cfg1[CFG1_PWRMON] <= 1'b0;
      end
      if (adp_reload) begin
        lim1 <= lim1_default(strap_done ? strap_in : strap);
      end else if (wr_go && i_avs_address == OFS_LIM1) begin
        lim1 <= merge(lim1, i_avs_writedata, i_avs_byteenable);
      end
      if (cfg_reload || (adp_reload && !cfg1[CFG1_PWRMON])) begin
        vmax <= vmax_default(strap_done ? strap_in : strap);
        vmin <= vmin_default(strap_done ? strap_in : strap);
      end else if (wr_go && i_avs_address == OFS_VMAX) begin
        vmax <= merge(vmax, i_avs_writedata, i_avs_byteenable);
      end else if (wr_go && i_avs_address == OFS_VMIN) begin
        vmin <= merge(vmin, i_avs_writedata, i_avs_byteenable);
      end
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= '0;
    end else if (rd_load) begin
      unique case (i_avs_address)
        OFS_CFG0: o_avs_readdata <= {16'h0000, cfg0};
        OFS_CFG1: o_avs_readdata <= {16'h0000, cfg1};
        OFS_CFG2: o_avs_readdata <= {16'h0000, cfg2};
        OFS_LIM1: o_avs_readdata <= {16'h0000, lim1};
        OFS_LIM2: o_avs_readdata <= {16'h0000, lim2};
        OFS_VMAX: o_avs_readdata <= {16'h0000, vmax};
        OFS_VMIN: o_avs_readdata <= {16'h0000, vmin};
        OFS_CHG:  o_avs_readdata <= {16'h0000, chg};
        OFS_STAT: o_avs_readdata <= {22'h000000, strap_valid, turbo, o_battery_switch_gate,
                                     o_adapter_switch_gate, strap, mode};
        default:  o_avs_readdata <= UNMAPPED_RD;
      endcase
    end
  end

  // mode sequencer; learn commands act on the accepted write
  logic cmd_enter, cmd_exit, learn_exit;
  assign cmd_enter = wr_go && i_avs_address == OFS_CMD && i_avs_byteenable[0]
                     && i_avs_writedata[CMD_LEARN_ENTER];
  assign cmd_exit  = wr_go && i_avs_address == OFS_CMD && i_avs_byteenable[0]
                     && i_avs_writedata[CMD_LEARN_EXIT];
  // exit threshold picked by config word one: minimum or maximum rail setpoint
  assign learn_exit = cmd_exit | (cfg1[CFG1_LEARN_EXIT] ? bat_lt_max : bat_lt_min)
                      | (bat_gone & ~bat_gone_q);
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mode <= CPPC_OFF;
      learn_pend <= 1'b0;
    end else begin
      unique case (mode)
        CPPC_OFF, CPPC_BAT, CPPC_ADP: begin
          if (adp_ok && o_adapter_switch_gate && cmd_enter) begin
            mode <= CPPC_LEARN;
            learn_pend <= 1'b1;
          end else if (adp_ok) begin
            mode <= CPPC_ADP;
          end else if (bat_ok) begin
            mode <= CPPC_BAT;
          end else begin
            mode <= CPPC_OFF;
          end
        end
        CPPC_LEARN: begin
          if (learn_exit) begin
            mode <= adp_ok ? CPPC_ADP : (bat_ok ? CPPC_BAT : CPPC_OFF);
            learn_pend <= 1'b0;
          end else if (rail_dec) begin
            learn_pend <= 1'b0;
          end
        end
      endcase
    end
  end

  // peak-assist: enter at rail margin, leave on charge or long low discharge
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      turbo <= 1'b0;
      dis_cnt <= '0;
    end else if (mode != CPPC_ADP || cfg0[CFG0_TURBO_DIS]) begin
      turbo <= 1'b0;
      dis_cnt <= '0;
    end else if (!turbo) begin
      turbo <= rail_margin;
      dis_cnt <= '0;
    end else if (chg_det || dis_cnt >= TURBO_EXIT_CYCLES[$bits(dis_cnt)-1:0]) begin
      turbo <= 1'b0;
      dis_cnt <= '0;
    end else begin
      dis_cnt <= dis_low ? dis_cnt + 1'b1 : '0;
    end
  end

  // gate drives and switcher control
  logic chg_nz;
  assign chg_nz = |chg;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_adapter_switch_gate <= 1'b0;
      o_battery_switch_gate <= 1'b0;
      o_switcher_en <= 1'b0;
      o_charge_en <= 1'b0;
    end else begin
      // adapter gate waits for a valid strap reading
      o_adapter_switch_gate <= adp_ok && strap_valid && !o_strap_current_en;
      unique case (mode)
        CPPC_BAT:   o_battery_switch_gate <= 1'b1;
        CPPC_LEARN: o_battery_switch_gate <= !learn_pend;
        CPPC_ADP:   o_battery_switch_gate <= chg_nz || (turbo && turbo_ld);
        default:    o_battery_switch_gate <= 1'b0;
      endcase
      o_switcher_en <= mode == CPPC_ADP && o_adapter_switch_gate && bias_ok;
      o_charge_en <= mode == CPPC_ADP && o_switcher_en && chg_nz && !bat_gone;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_input_limit_active <= 1'b0;
      o_input_limit_sel <= LIM1_A01;
      o_input_vref_sel <= 2'h0;
      o_freq_sel <= 3'h0;
      o_system_power_monitor <= 1'b0;
      o_battery_current_monitor <= 1'b0;
      o_period_stretch <= 1'b0;
    end else begin
      o_input_limit_active <= o_switcher_en && (adp_ilim || adp_vlim);
      o_input_limit_sel <= cfg2[CFG2_TWO_LEVEL] ? lim2 : lim1;
      o_input_vref_sel <= cfg0[CFG0_VREF_LO+1:CFG0_VREF_LO];
      o_freq_sel <= cfg1[CFG1_FREQ_LO+2:CFG1_FREQ_LO];
      o_system_power_monitor <= cfg1[CFG1_PWRMON] && (mode != CPPC_BAT || bat_pm_ok);
      o_battery_current_monitor <= cfg1[CFG1_BATMON];
      o_period_stretch <= o_switcher_en && ls_short;
    end
  end
endmodule // cppc_top
